/* tim_cc_channels.sv */
// Two-channel capture, compare and PWM logic sharing one counter.
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`include "tim_cc_map.svh"
module tim_cc_channels
#(
	parameter int CW = `CNT_W
)
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic                  tick,
	input  wire logic                  counterStop,
	input  wire logic                  counterClear,
	input  wire logic [CW-1:0]         moduloVal,
	input  wire tim_cc_pkg::chan_cfg_s ch0Cfg,
	input  wire tim_cc_pkg::chan_cfg_s ch1Cfg,
	input  wire tim_cc_pkg::val_wr_s   ch0Wr,
	input  wire tim_cc_pkg::val_wr_s   ch1Wr,
	input  wire logic                  ch0FlagClr,
	input  wire logic                  ch1FlagClr,
	input  wire logic                  wrapFlagClr,
	input  wire logic                  ch0PinIn,
	input  wire logic                  ch1PinIn,
	output logic                       ch0PinOut,
	output logic                       ch0PinOe_n,
	output logic                       ch1PinOut,
	output logic                       ch1PinOe_n,
	output logic                       ch1PinReleased,
	output logic [CW-1:0]              ch0Value,
	output logic [CW-1:0]              ch1Value,
	output logic [CW-1:0]              counterValue,
	output logic                       ch0Flag,
	output logic                       ch1Flag,
	output logic                       wrapFlag,
	output logic                       ch0IntReq,
	output logic                       ch1IntReq,
	output logic                       bufOwnerCh1
);
	import tim_cc_pkg::*;

	// ****************************************************************
	// Shared counter
	// ****************************************************************
	logic [CW-1:0] count; // Live counter value.
	logic          wrap;  // One-cycle wrap event.

	// The single counter that every channel compares against.
	tim_cc_counter #(.CW(CW)) counterInst
	(
		.ref_clk      (ref_clk),
		.rst          (rst),
		.tick         (tick),
		.counterStop  (counterStop),
		.counterClear (counterClear),
		.moduloVal    (moduloVal),
		.count        (count),
		.wrap         (wrap)
	);

	// ****************************************************************
	// Pin synchronisers and per-channel wires
	// ****************************************************************
	chan_cfg_s     cfg     [2];  // Configuration per channel.
	val_wr_s       wr      [2];  // Value write per channel.
	logic [1:0]    pinIn;        // Raw pin inputs.
	logic [1:0]    pinRise;      // Synchronised rising edges.
	logic [1:0]    pinFall;      // Synchronised falling edges.
	logic [1:0]    flagClr;      // Flag clear strobes.
	logic [CW-1:0] valReg  [2];  // Channel value registers.
	logic [CW-1:0] valNext [2];  // Next channel values.
	logic [1:0]    flagReg;      // Sticky channel flags.
	logic [1:0]    flagNext;     // Next channel flags.
	logic [1:0]    pinReg;       // Channel pin output state.
	logic [1:0]    pinNext;      // Next pin output state.
	logic [1:0]    capEvent;     // Capture event this cycle.
	logic [1:0]    cmpEvent;     // Compare event this cycle.
	logic [1:0]    isOutput;     // Channel drives its pin.
	logic          linked;       // Channels 0 and 1 paired.
	logic          wrapFlagReg;  // Sticky wrap flag.
	logic [CW-1:0] cntReg;       // Registered counter copy.

	assign cfg[0]   = ch0Cfg;
	assign cfg[1]   = ch1Cfg;
	assign wr[0]    = ch0Wr;
	assign wr[1]    = ch1Wr;
	assign pinIn    = {ch1PinIn, ch0PinIn};
	assign flagClr  = {ch1FlagClr, ch0FlagClr};
	// Buffer link comes only from channel 0's mode field.
	assign linked   = (ch0Cfg.modeSel == `MODE_BUF);

	// ****************************************************************
	// Buffered ownership
	// ****************************************************************
	owner_e ownerReg;    // Set currently in control.
	owner_e ownerNext;   // Next owner.
	owner_e lastWrReg;   // Set written most recently.
	owner_e lastWrNext;  // Next last-written record.

	// Record the most recent write; channel 1 wins a tie.
	assign lastWrNext = wr[1].wrEn ? OWN_CH1 :
		(wr[0].wrEn ? OWN_CH0 : lastWrReg);
	// Ownership moves only at wrap while linked, and is held at channel 0 unlinked.
	assign ownerNext = !linked ? OWN_CH0 :
		(wrap ? lastWrNext : ownerReg);

	// Owner and last-write tracking.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ownerReg  <= OWN_CH0;
			lastWrReg <= OWN_CH0;
		end
		else
		begin
			ownerReg  <= ownerNext;
			lastWrReg <= linked ? lastWrNext : OWN_CH0;
		end
	end

	// Value governing the linked compare.
	logic [CW-1:0] bufVal;
	assign bufVal = (ownerReg == OWN_CH1) ? valReg[1] : valReg[0];
	// Count this counter clock moves onto, so a pulse lasts value clocks.
	logic [CW-1:0] cntStep;
	assign cntStep = (count == moduloVal) ? CW'(`CNT_ZERO) :
		count + CW'(`CNT_ONE);

	// ****************************************************************
	// Per-channel logic
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : chanGen
			logic          edgeHit;    // Selected capture edge seen.
			logic          capMode;    // Channel is in capture mode.
			logic          cmpMode;    // Channel is in compare mode.
			logic [CW-1:0] cmpVal;     // Value being compared.
			logic          chanOff;    // Channel 1 unused while linked.
			logic          wrapToggle; // Pin toggles at wrap.
			logic          cmpAct;     // Pin value after compare.

			// Synchroniser for this channel's pin.
			tim_cc_sync syncInst
			(
				.ref_clk (ref_clk),
				.rst     (rst),
				.pinIn   (pinIn[gi]),
				.level   (),
				.rise    (pinRise[gi]),
				.fall    (pinFall[gi])
			);

			assign chanOff = (gi == 1) && linked;
			assign capMode = !chanOff &&
				(cfg[gi].modeSel == `MODE_CAPTURE);
			assign cmpMode = !chanOff && !capMode;
			// Edge selection per channel.
			assign edgeHit =
				((cfg[gi].edgeSel == `ELS_RISE) && pinRise[gi]) ||
				((cfg[gi].edgeSel == `ELS_FALL) && pinFall[gi]) ||
				((cfg[gi].edgeSel == `ELS_BOTH) &&
				 (pinRise[gi] || pinFall[gi]));
			assign capEvent[gi] = capMode && edgeHit;
			// Channel 0 compares the buffered set when linked.
			assign cmpVal = ((gi == 0) && linked) ? bufVal : valReg[gi];
			// Match checked once per counter clock on equality.
			assign cmpEvent[gi] = cmpMode && tick && !counterStop &&
				(cntStep == cmpVal);
			assign isOutput[gi] = cmpMode &&
				(cfg[gi].edgeSel != `ELS_NONE);
			assign wrapToggle = wrap && cfg[gi].toggleOnWrap;

			// Compare action; full duty with wrap toggle suppresses the compare.
			assign cmpAct =
				(cfg[gi].edgeSel == `ELS_TOGGLE) ? ~pinReg[gi] :
				(cfg[gi].edgeSel == `ELS_SET)    ? 1'b1 : 1'b0;

			// Next pin state from wrap toggles and compares.
			always_comb
			begin
				pinNext[gi] = pinReg[gi];
				if (!isOutput[gi])
					pinNext[gi] = pinReg[gi];
				else if (cfg[gi].fullDuty && cfg[gi].toggleOnWrap)
					pinNext[gi] = (cfg[gi].edgeSel == `ELS_CLEAR);
				else if (cmpEvent[gi] && !(wrapToggle &&
					cfg[gi].edgeSel == `ELS_TOGGLE))
					pinNext[gi] = cmpAct;
				else if (wrapToggle)
					pinNext[gi] = ~pinReg[gi];
			end

			// Capture overwrites a write in the same cycle.
			assign valNext[gi] = capEvent[gi] ? count :
				(wr[gi].wrEn ? wr[gi].wrData : valReg[gi]);
			// Sticky flag; a new event beats a clear.
			assign flagNext[gi] = (capEvent[gi] || cmpEvent[gi]) ? 1'b1 :
				(flagClr[gi] ? 1'b0 : flagReg[gi]);

			// Channel storage.
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					valReg[gi]  <= `VAL_RESET;
					flagReg[gi] <= 1'b0;
					pinReg[gi]  <= 1'b0;
				end
				else
				begin
					valReg[gi]  <= valNext[gi];
					flagReg[gi] <= flagNext[gi];
					pinReg[gi]  <= pinNext[gi];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Wrap flag and registered outputs
	// ****************************************************************
	// Sticky wrap flag with set winning over clear.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			wrapFlagReg <= 1'b0;
		else if (wrap)
			wrapFlagReg <= 1'b1;
		else if (wrapFlagClr)
			wrapFlagReg <= 1'b0;
	end

	// Counter copy so the output comes from a flip-flop.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			cntReg <= `CNT_ZERO;
		else
			cntReg <= count;
	end

	// Output enables, active low while driving.
	logic [1:0] oeNReg; // Registered active-low enables.
	logic       relReg; // Registered pin 1 release.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			oeNReg <= 2'h3;
			relReg <= 1'b0;
		end
		else
		begin
			oeNReg <= ~isOutput;
			relReg <= linked;
		end
	end

	assign ch0PinOut      = pinReg[0];
	assign ch1PinOut      = pinReg[1];
	assign ch0PinOe_n     = oeNReg[0];
	assign ch1PinOe_n     = oeNReg[1];
	assign ch1PinReleased = relReg;
	assign ch0Value       = valReg[0];
	assign ch1Value       = valReg[1];
	assign counterValue   = cntReg;
	assign ch0Flag        = flagReg[0];
	assign ch1Flag        = flagReg[1];
	assign wrapFlag       = wrapFlagReg;
	// Requests are the flags ANDed with enables inside the flops' path.
	logic [1:0] irqReg; // Registered interrupt requests.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			irqReg <= 2'h0;
		else
			irqReg <= flagNext & {cfg[1].intEnable & ~linked,
				cfg[0].intEnable};
	end
	assign ch0IntReq   = irqReg[0];
	assign ch1IntReq   = irqReg[1];
	assign bufOwnerCh1 = (ownerReg == OWN_CH1);

endmodule : tim_cc_channels

/* tim_cc_map.svh */
// Constant definitions for the timer capture/compare/PWM channel block.
`ifndef TIM_CC_MAP_SVH
`define TIM_CC_MAP_SVH

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define CNT_W        16
`define CNT_ZERO     16'h0000
`define MOD_RESET    16'hFFFF
`define VAL_RESET    16'h0000
`define CNT_ONE      16'h0001

// ****************************************************************
// Mode select encodings (two-bit channel_mode_select field)
// ****************************************************************
`define MODE_CAPTURE 2'h0
`define MODE_UNBUF   2'h1
`define MODE_BUF     2'h2

// ****************************************************************
// Edge/level select encodings
// ****************************************************************
`define ELS_NONE     2'h0
`define ELS_RISE     2'h1
`define ELS_FALL     2'h2
`define ELS_BOTH     2'h3
`define ELS_TOGGLE   2'h1
`define ELS_CLEAR    2'h2
`define ELS_SET      2'h3

`endif

/* tim_cc_pkg.sv */
// Package with the types shared by the timer channel block.
package tim_cc_pkg;

	// ****************************************************************
	// Per-channel configuration carried from the control ports
	// ****************************************************************
	typedef struct packed {
		logic [1:0] modeSel;     // Mode select: capture, unbuffered, buffered.
		logic [1:0] edgeSel;     // Capture edge or compare action.
		logic       toggleOnWrap; // Toggle the pin on counter wrap.
		logic       fullDuty;    // Force 100 percent duty with toggle.
		logic       intEnable;   // Channel interrupt enable.
	} chan_cfg_s;

	// ****************************************************************
	// Register write strobe with data for one channel value
	// ****************************************************************
	typedef struct packed {
		logic        wrEn;        // One-cycle write strobe.
		logic [15:0] wrData;      // Value written.
	} val_wr_s;

	// Buffered control owner.
	typedef enum logic {OWN_CH0, OWN_CH1} owner_e;

endpackage : tim_cc_pkg

/* tim_cc_sync.sv */
// Two-flip-flop synchroniser with edge detection after the second stage.
`timescale 1ns/1ps
module tim_cc_sync
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic pinIn,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	// ****************************************************************
	// Synchroniser stages
	// ****************************************************************
	logic stage1Reg; // First stage, read only by the second.
	logic stage2Reg; // Second stage, safe to use.
	logic stage3Reg; // Delayed copy for edge detection.

	// Shift the pin through three flip-flops.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			stage1Reg <= 1'b0;
			stage2Reg <= 1'b0;
			stage3Reg <= 1'b0;
		end
		else
		begin
			stage1Reg <= pinIn;
			stage2Reg <= stage1Reg;
			stage3Reg <= stage2Reg;
		end
	end

	// Edges are seen between the second and third stages.
	assign level = stage2Reg;
	assign rise  = stage2Reg & ~stage3Reg;
	assign fall  = ~stage2Reg & stage3Reg;

endmodule : tim_cc_sync

/* tim_cc_counter.sv */
// Shared 16-bit counter with modulo wrap and a tick enable.
`timescale 1ns/1ps
`include "tim_cc_map.svh"
module tim_cc_counter
#(
	parameter int CW = `CNT_W
)
(
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic          tick,
	input  wire logic          counterStop,
	input  wire logic          counterClear,
	input  wire logic [CW-1:0] moduloVal,
	output logic      [CW-1:0] count,
	output logic               wrap
);

	// ****************************************************************
	// Counter
	// ****************************************************************
	logic [CW-1:0] countReg;  // Current count.
	logic          atModulo;  // Count equals the modulo value.
	logic          advance;   // Count advances this cycle.

	assign atModulo = (countReg == moduloVal);
	assign advance  = tick & ~counterStop;
	// Wrap fires on the counter clock that leaves the modulo value.
	assign wrap     = advance & atModulo;
	assign count    = countReg;

	// Count up, returning to zero after the modulo value.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			countReg <= `CNT_ZERO;
		else if (counterClear)
			countReg <= `CNT_ZERO;
		else if (wrap)
			countReg <= `CNT_ZERO;
		else if (advance)
			countReg <= countReg + CW'(`CNT_ONE);
	end

endmodule : tim_cc_counter

/* tim_cc_properties.sv */
// Concurrent checks on the ports of the timer channel block.
`timescale 1ns/1ps
`include "tim_cc_map.svh"
module tim_cc_properties
#(
	parameter int CW = `CNT_W
)
(
	input wire logic                  ref_clk,
	input wire logic                  rst,
	input wire logic                  tick,
	input wire logic                  counterStop,
	input wire logic                  counterClear,
	input wire logic [CW-1:0]         moduloVal,
	input wire tim_cc_pkg::chan_cfg_s ch0Cfg,
	input wire tim_cc_pkg::val_wr_s   ch0Wr,
	input wire logic                  ch0PinOut,
	input wire logic                  ch0PinOe_n,
	input wire logic                  ch1PinReleased,
	input wire logic [CW-1:0]         ch0Value,
	input wire logic [CW-1:0]         counterValue,
	input wire logic                  ch0Flag,
	input wire logic                  ch0IntReq,
	input wire logic                  ch1IntReq
);
	import tim_cc_pkg::*;
	// ****************************************************************
	// Clocking and the named steps
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Two edges of counting, or of standing still.
	sequence run2; (tick && !counterStop && !counterClear)[*2]; endsequence
	sequence hold2; (counterStop && !counterClear)[*2]; endsequence
	// PWM set-ups on channel 0 with clear-on-compare.
	sequence fullCfg; ch0Cfg.modeSel == `MODE_UNBUF &&
		ch0Cfg.edgeSel == `ELS_CLEAR && ch0Cfg.toggleOnWrap &&
		ch0Cfg.fullDuty; endsequence
	sequence zeroCfg; ch0Cfg.modeSel == `MODE_UNBUF &&
		ch0Cfg.edgeSel == `ELS_CLEAR && !ch0Cfg.toggleOnWrap &&
		!ch0Cfg.fullDuty; endsequence
	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_count_step: assert property (
		run2 ##0 counterValue != moduloVal |=>
		counterValue == $past(counterValue) + 16'h0001)
		else $error("counter did not step by one");
	a_wrap_zero: assert property (
		run2 ##0 counterValue == moduloVal |=> counterValue == `CNT_ZERO)
		else $error("counter did not wrap to zero");
	a_stop_hold: assert property (
		hold2 |=> $stable(counterValue))
		else $error("counter moved while stopped");
	a_int_masked: assert property (
		(!ch0Cfg.intEnable)[*2] |-> !ch0IntReq)
		else $error("masked request raised");
	a_ch1_masked: assert property (
		ch1PinReleased[*2] |-> !ch1IntReq)
		else $error("linked channel one raised a request");
	a_link_release: assert property (
		(ch0Cfg.modeSel == `MODE_BUF)[*2] |-> ch1PinReleased)
		else $error("pin one not released while linked");
	a_full_duty: assert property (
		fullCfg[*3] |-> ch0PinOut && !ch0PinOe_n)
		else $error("full duty output not high");
	a_zero_duty: assert property (
		zeroCfg[*2] ##0 !ch0PinOut |=> !ch0PinOut)
		else $error("zero duty output rose");
	a_capture_flag: assert property (
		(ch0Cfg.modeSel == `MODE_CAPTURE)[*2] ##0 $changed(ch0Value)
		##0 !$past(ch0Wr.wrEn) |-> ch0Flag)
		else $error("capture without flag");
	a_capture_oe: assert property (
		(ch0Cfg.modeSel == `MODE_CAPTURE)[*2] |-> ch0PinOe_n)
		else $error("capture pin driven");
endmodule : tim_cc_properties

bind tim_cc_channels tim_cc_properties #(.CW(CW)) props_i (.ref_clk,
	.rst, .tick, .counterStop, .counterClear, .moduloVal, .ch0Cfg,
	.ch0Wr, .ch0PinOut, .ch0PinOe_n, .ch1PinReleased, .ch0Value,
	.counterValue, .ch0Flag, .ch0IntReq, .ch1IntReq);

/* tim_cc_pin_model.sv */
// External signal sources standing on the two channel pins.
`timescale 1ns/1ps
module tim_cc_pin_model
(
	input  wire logic [1:0] extLevel,
	input  wire logic       ch0PinOut,
	input  wire logic       ch0PinOe_n,
	input  wire logic       ch1PinOut,
	input  wire logic       ch1PinOe_n,
	output logic            ch0PinIn,
	output logic            ch1PinIn
);
	// The wire follows the block while it drives, else the outside
	// source; the delay keeps edges off the clock grid.
	assign #13 ch0PinIn = ch0PinOe_n ? extLevel[0] : ch0PinOut;
	assign #13 ch1PinIn = ch1PinOe_n ? extLevel[1] : ch1PinOut;
endmodule : tim_cc_pin_model

/* testbench.sv */
// Self-checking bench for the timer channel block.
`timescale 1ns/1ps
`include "tim_cc_map.svh"
module testbench;
	import tim_cc_pkg::*;
	typedef struct packed {logic [1:0] kind; logic [15:0] a, b;} note_s;
	logic ref_clk = 0, rst = 1, counterStop = 1, counterClear = 0;
	logic ch0FlagClr = 0, ch1FlagClr = 0, wrapFlagClr = 0;
	logic [15:0] moduloVal = 16'h00FF;
	chan_cfg_s ch0Cfg = 7'h01, ch1Cfg = '0;
	val_wr_s ch0Wr = '0, ch1Wr = '0;
	logic [1:0] extLevel = 2'h0;
	logic ch0PinIn, ch1PinIn, ch0PinOut, ch0PinOe_n, ch1PinOut, ch1PinOe_n;
	logic ch1PinReleased, ch0Flag, ch1Flag, wrapFlag, ch0IntReq, ch1IntReq;
	logic bufOwnerCh1, f0, f1, p0, arm = 0, capOn = 0;
	logic [15:0] ch0Value, ch1Value, counterValue, hiCnt, perCnt, n16;
	logic [15:0] perLast;
	note_s q[$];
	int bad_count = 0, checks = 0, seed = 74;

	tim_cc_channels tim_cc_channels_i (.ref_clk, .rst, .tick(1'b1),
		.counterStop, .counterClear, .moduloVal, .ch0Cfg, .ch1Cfg, .ch0Wr,
		.ch1Wr, .ch0FlagClr, .ch1FlagClr, .wrapFlagClr, .ch0PinIn,
		.ch1PinIn, .ch0PinOut, .ch0PinOe_n, .ch1PinOut, .ch1PinOe_n,
		.ch1PinReleased, .ch0Value, .ch1Value, .counterValue, .ch0Flag,
		.ch1Flag, .wrapFlag, .ch0IntReq, .ch1IntReq, .bufOwnerCh1);
	tim_cc_pin_model tim_cc_pin_model_i (.extLevel, .ch0PinOut,
		.ch0PinOe_n, .ch1PinOut, .ch1PinOe_n, .ch0PinIn, .ch1PinIn);

	// Clock of 100 ns period.
	always #50 ref_clk = ~ref_clk;

	// Steps n clock edges, then waits the fixed drive delay.
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	// Compares one value and counts the outcome.
	task automatic chk(input string nm, input logic [15:0] e, g);
		checks++;
		if (e !== g)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Writes one channel value with a single strobe.
	task automatic wr(input int c, input logic [15:0] v);
		if (c)
			ch1Wr = {1'b1, v};
		else
			ch0Wr = {1'b1, v};
		cyc(1);
		ch0Wr.wrEn = 0;
		ch1Wr.wrEn = 0;
	endtask : wr

	// Clears the counter, runs it n counts, then freezes it.
	task automatic setCount(input logic [15:0] n);
		counterClear = 1;
		cyc(1);
		counterClear = 0;
		counterStop = 0;
		cyc(n);
		counterStop = 1;
		cyc(1);
	endtask : setCount

	// Waits, bounded, for the pin to change to level v.
	task automatic waitPin(input logic v);
		for (int t = 0; t < 1000; t++)
		begin
			cyc(1);
			if (ch0PinOut === v && p0 !== v) break;
		end
	endtask : waitPin

	// Expects the next two pulses, then waits for both.
	task automatic pulses(input logic [15:0] w1, w2);
		q.push_back({2'h2, w1, moduloVal + 16'h0001});
		q.push_back({2'h2, w2, moduloVal + 16'h0001});
		arm = 1;
		for (int t = 0; t < 2000 && q.size() > 0; t++) cyc(1);
		arm = 0;
		chk("pending notes", 16'h0000, 16'(q.size()));
	endtask : pulses

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	// Watcher: takes the oldest note at each capture, and at each pulse end while arm is set.
	always @(negedge ref_clk)
	begin : watch
		note_s n;
		logic k;
		perCnt = rst ? 16'h0000 : perCnt + 16'h0001;
		hiCnt = rst ? 16'h0000 : hiCnt + 16'(ch0PinOut);
		if (capOn && (ch0Flag && !f0 || ch1Flag && !f1))
		begin
			n = q.size() ? q.pop_front() : '1;
			k = ch1Flag && !f1;
			chk("capture channel", n.kind, 16'(k));
			chk("capture value", n.a, k ? ch1Value : ch0Value);
			chk("capture request", k ? ch1Cfg.intEnable :
				ch0Cfg.intEnable, k ? ch1IntReq : ch0IntReq);
		end
		// The period runs from one wrap toggle (a rise) to the next.
		if (p0 === 1'b0 && ch0PinOut === 1'b1)
		begin
			perLast = perCnt;
			perCnt = 0;
		end
		if (p0 === 1'b1 && ch0PinOut === 1'b0)
		begin
			if (arm && q.size() > 0)
			begin
				n = q.pop_front();
				chk("pulse width", n.a, hiCnt);
				chk("pwm period", n.b, perLast);
			end
			hiCnt = 0;
		end
		f0 = ch0Flag;
		f1 = ch1Flag;
		p0 = ch0PinOut;
	end

	// Watchdog over the expected length of the run.
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		stop_test();
	end

	// Main sequence.
	initial
	begin
		cyc(20);
		rst = 0;
		cyc(1);
		capOn = 1;
		for (int c = 0; c < 2; c++)
			for (int e = 1; e < 4; e++)
			begin
				if (c)
					ch1Cfg.edgeSel = e;
				else
					ch0Cfg.edgeSel = e;
				repeat (2)
				begin
					n16 = 16'h0001 + 16'($unsigned($random(seed)) % 200);
					setCount(n16);
					chk("counter", n16, counterValue);
					extLevel[c] = ~extLevel[c];
					if (e == 3 || (e == 1) == extLevel[c])
						q.push_back({c[1:0], n16, 16'h0000});
					cyc(8);
					{ch1FlagClr, ch0FlagClr} = c ? 2'h2 : 2'h1;
					cyc(1);
					{ch1FlagClr, ch0FlagClr} = 2'h0;
				end
			end
		chk("stray captures", 16'h0000, 16'(q.size()));
		chk("pin one enable", 16'h0001, ch1PinOe_n);
		capOn = 0;
		$display("capture test done");
		wr(0, 16'h0080);
		ch0Cfg = '{`MODE_UNBUF, `ELS_CLEAR, 1'b1, 1'b0, 1'b1};
		counterClear = 1;
		cyc(1);
		counterClear = 0;
		counterStop = 0;
		cyc(600);
		waitPin(1);
		pulses(16'h0080, 16'h0080);
		chk("compare flag", 16'h0001, ch0Flag);
		chk("compare request", 16'h0001, ch0IntReq);
		chk("wrap flag", 16'h0001, wrapFlag);
		chk("pin zero enable", 16'h0000, ch0PinOe_n);
		waitPin(0);
		wr(0, 16'h0040);
		pulses(16'h0040, 16'h0040);
		waitPin(1);
		wr(0, 16'h0080);
		pulses(16'h0080, 16'h0080);
		ch0Cfg.toggleOnWrap = 0;
		cyc(600);
		chk("zero duty", 16'h0000, ch0PinOut);
		ch0Cfg.toggleOnWrap = 1;
		ch0Cfg.fullDuty = 1;
		cyc(4);
		chk("full duty", 16'h0001, ch0PinOut);
		ch0Cfg.fullDuty = 0;
		$display("unbuffered test done");
		ch0Cfg.modeSel = `MODE_BUF;
		cyc(600);
		waitPin(1);
		wr(1, 16'h00C8);
		pulses(16'h0080, 16'h00C8);
		chk("owner", 16'h0001, bufOwnerCh1);
		chk("pin one free", 16'h0001, ch1PinReleased);
		chk("pin one level", 16'h0000, ch1PinOut);
		waitPin(1);
		wr(0, 16'h0020);
		pulses(16'h00C8, 16'h0020);
		chk("owner", 16'h0000, bufOwnerCh1);
		$display("buffered test done");
		stop_test();
	end
endmodule : testbench
